// ==== hw/dbfs_chan.sv ====
`timescale 1ns/10ps
module dbfs_chan
    import dbfs_pkg::*;
#(
    parameter int SS_CYC = SS_CYC_DEF
)(
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_nrst,
    // Control
    input  wire logic i_go,
    input  wire logic i_hot,
    input  wire logic i_cyc_start,
    // Analog status, synchronised
    input  wire logic i_ilim,
    input  wire logic i_out_ok,
    input  wire logic i_boot_low,
    // Outputs
    output logic      o_switch_on,
    output logic      o_pull_down,
    output logic      o_soft_start,
    output logic      o_good,
    output logic      o_oc_fault
);
    import dbfs_pkg::*;

    dbfs_state_t       state_q, state_d;
    logic [SS_W-1:0]   ss_cnt_q;
    logic [3:0]        hic_cnt_q;
    logic [4:0]        oc_cnt_q;
    logic              oc_flag_q;
    logic              trip_cyc_q;
    logic              sw_q;
    logic [BOOT_W-1:0] boot_cnt_q;
    logic              pd_q;
    logic              good_q;

    wire ss_done  = (ss_cnt_q == SS_W'(SS_CYC - 1));
    wire switching = (state_q == DBFS_SOFT) || (state_q == DBFS_RUN);
    wire trip     = switching && sw_q && i_ilim;
    wire overflow = i_cyc_start && trip_cyc_q
                    && (oc_cnt_q == 5'(OC_OVF_COUNT));
    wire hic_done = ss_done && (hic_cnt_q == 4'(HICCUP_SS - 1));

    // =========================================================
    // Channel sequence
    // =========================================================
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            DBFS_OFF:
                if (i_go && !i_hot) state_d = DBFS_SOFT;
            DBFS_SOFT:
                if (ss_done) state_d = DBFS_RUN;
            DBFS_HICCUP:
                if (hic_done) state_d = DBFS_SOFT;
            default:
                state_d = state_q;
        endcase
        if (switching && overflow)
            state_d = DBFS_HICCUP;
        if (!i_go || i_hot)
            state_d = DBFS_OFF;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
            state_q <= DBFS_OFF;
        else
            state_q <= state_d;
    end

    // =========================================================
    // Soft-start and hiccup timers
    // =========================================================
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst || state_d != state_q)
        begin
            ss_cnt_q  <= '0;
            hic_cnt_q <= '0;
        end
        else if (ss_done)
        begin
            ss_cnt_q  <= '0;
            hic_cnt_q <= hic_cnt_q + 4'h1;
        end
        else
            ss_cnt_q <= ss_cnt_q + SS_W'(1);
    end

    // =========================================================
    // Overcurrent counting
    // =========================================================
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst || !switching)
        begin
            oc_cnt_q   <= OC_RST;
            oc_flag_q  <= 1'b0;
            trip_cyc_q <= 1'b0;
        end
        else if (i_cyc_start)
        begin
            trip_cyc_q <= 1'b0;
            if (!trip_cyc_q)
            begin
                oc_cnt_q  <= OC_RST;
                oc_flag_q <= 1'b0;
            end
        end
        else if (trip && !trip_cyc_q)
        begin
            trip_cyc_q <= 1'b1;
            oc_flag_q  <= 1'b1;
            oc_cnt_q   <= oc_flag_q ? oc_cnt_q + 5'h01
                                    : OC_FIRST;
        end
    end

    // =========================================================
    // Power switch
    // =========================================================
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst || !switching || overflow || i_hot)
            sw_q <= 1'b0;
        else if (i_cyc_start)
            sw_q <= 1'b1;
        else if (i_ilim)
            sw_q <= 1'b0;
    end

    // =========================================================
    // Boot refresh pulse
    // =========================================================
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            boot_cnt_q <= '0;
            pd_q       <= 1'b0;
        end
        else if (boot_cnt_q != '0)
        begin
            boot_cnt_q <= boot_cnt_q - BOOT_W'(1);
            pd_q       <= (boot_cnt_q != BOOT_W'(1));
        end
        else if (i_boot_low && !sw_q)
        begin
            boot_cnt_q <= BOOT_W'(BOOT_PULSE_CYC);
            pd_q       <= 1'b1;
        end
        else
            pd_q <= 1'b0;
    end

    // =========================================================
    // Output good flag
    // =========================================================
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
            good_q <= 1'b0;
        else
            good_q <= (state_d == DBFS_RUN) && i_out_ok;
    end

    assign o_switch_on  = sw_q;
    assign o_pull_down  = pd_q;
    assign o_soft_start = (state_q == DBFS_SOFT);
    assign o_good       = good_q;
    assign o_oc_fault   = (state_q == DBFS_HICCUP);
endmodule : dbfs_chan

// ==== hw/dbfs_pkg.sv ====
// How it works
// - Current trip ends on-time until next cycle
// - First trip loads counter one, sets flag
// - Seventeen trips overflow: shutdown, good low
// - Hiccup waits eight soft-start periods
// - After wait clear fault, soft-start again
// - Overflow during retry repeats hiccup
// - Over-temperature shuts both channels down
// - Temperature recovered restarts with soft-start
// - Boot undervoltage gives 400 ns pull-down
// - Enable one high, two floating: one first
// - Enable two high, one floating: two first
// - Both enables high start together
// - Sync falling edge starts switching cycle
// - Channel frequency is half sync frequency
// - Frequency pin at rail gives 500 kHz
// - Enable rise starts 2 ms soft-start
// - Good flag low when off, starting, low
package dbfs_pkg;
    // =========================================================
    // Timing
    // =========================================================
    localparam int CLK_HZ         = 25_000_000;
    localparam int CLK_NS         = 40;
    localparam int BOOT_PULSE_NS  = 400;
    localparam int BOOT_PULSE_CYC = (BOOT_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SS_TIME_US     = 2000;
    localparam int SS_CYC_DEF     = SS_TIME_US * (CLK_HZ / 1_000_000);
    localparam int DEF_FREQ_HZ    = 500_000;
    localparam int DEF_PER_CYC    = CLK_HZ / DEF_FREQ_HZ;
    localparam int OC_OVF_COUNT   = 17;
    localparam int HICCUP_SS      = 8;
    localparam logic [4:0] OC_FIRST = 5'h01;
    localparam logic [4:0] OC_RST   = 5'h00;
    localparam int SS_W           = 20;
    localparam int PER_W          = 6;
    localparam int BOOT_W         = 4;

    // =========================================================
    // Channel states
    // =========================================================
    typedef enum logic [2:0] {
        DBFS_OFF,
        DBFS_WAIT,
        DBFS_SOFT,
        DBFS_RUN,
        DBFS_HICCUP
    } dbfs_state_t;
endpackage : dbfs_pkg

// ==== hw/dbfs_top.sv ====
`timescale 1ns/10ps
module dbfs_top
    import dbfs_pkg::*;
#(
    parameter int SS_CYC = SS_CYC_DEF
)(
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_nrst,
    // Board enables, sensed as driven high and floating
    input  wire logic i_first_channel_enable_high,
    input  wire logic i_first_channel_enable_float,
    input  wire logic i_second_channel_enable_high,
    input  wire logic i_second_channel_enable_float,
    // Frequency and sync
    input  wire logic i_frequency_set_pin_at_rail,
    input  wire logic i_external_sync_input,
    // Analog comparators, per channel except the shared thermal pair
    input  wire logic [1:0] i_ilim_trip,
    input  wire logic [1:0] i_output_above_90,
    input  wire logic [1:0] i_boot_low,
    input  wire logic       i_over_temp,
    input  wire logic       i_temp_recovered,
    // Power stage controls
    output logic [1:0] o_switch_node_on,
    output logic [1:0] o_switch_node_pull_down,
    output logic [1:0] o_soft_start,
    output logic [1:0] o_output_good_flag,
    output logic [1:0] o_oc_fault,
    output logic       o_thermal_shutdown
);
    import dbfs_pkg::*;

    // =========================================================
    // Input synchronisers
    // =========================================================
    localparam int NIN = 14;
    wire [NIN-1:0] raw = {i_first_channel_enable_high,
        i_first_channel_enable_float, i_second_channel_enable_high,
        i_second_channel_enable_float, i_frequency_set_pin_at_rail,
        i_external_sync_input, i_ilim_trip, i_output_above_90,
        i_boot_low, i_over_temp, i_temp_recovered};
    logic [NIN-1:0] s1_q, s2_q;
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            s1_q <= '0;
            s2_q <= '0;
        end
        else
        begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end
    wire       en1_hi  = s2_q[13];
    wire       en1_fl  = s2_q[12];
    wire       en2_hi  = s2_q[11];
    wire       en2_fl  = s2_q[10];
    wire       fs_rail = s2_q[9];
    wire       sync    = s2_q[8];
    wire [1:0] ilim    = s2_q[7:6];
    wire [1:0] ok90    = s2_q[5:4];
    wire [1:0] bootl   = s2_q[3:2];
    wire       hot_in  = s2_q[1];
    wire       cool    = s2_q[0];

    // =========================================================
    // Thermal shutdown with recovery latch
    // =========================================================
    logic hot_q;
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
            hot_q <= 1'b0;
        else if (hot_in)
            hot_q <= 1'b1;
        else if (cool)
            hot_q <= 1'b0;
    end

    // =========================================================
    // Switching cycle timing
    // =========================================================
    logic sync_d_q, sync_tog_q, sync_seen_q;
    logic [PER_W-1:0] per_q;
    wire sync_fall = sync_d_q && !sync;
    wire osc_tick  = (per_q == PER_W'(DEF_PER_CYC - 1));
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            sync_d_q    <= 1'b0;
            sync_tog_q  <= 1'b0;
            sync_seen_q <= 1'b0;
            per_q       <= '0;
        end
        else
        begin
            sync_d_q <= sync;
            per_q    <= osc_tick ? '0 : per_q + PER_W'(1);
            if (sync_fall)
            begin
                sync_seen_q <= 1'b1;
                sync_tog_q  <= !sync_tog_q;
            end
        end
    end
    // Alternate sync edges feed the two channels out of phase
    wire [1:0] cyc_start = sync_seen_q
        ? {sync_fall && sync_tog_q, sync_fall && !sync_tog_q}
        : {2{osc_tick && fs_rail}};

    // =========================================================
    // Start order
    // =========================================================
    wire both_fl = en1_fl && en2_fl;
    wire [1:0] go;
    assign go[0] = !both_fl && (en1_hi
                   || (en1_fl && en2_hi && ok90[1]));
    assign go[1] = !both_fl && (en2_hi
                   || (en2_fl && en1_hi && ok90[0]));

    // =========================================================
    // Channels
    // =========================================================
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_ch
            logic sw, pd, ss, pg, oc;
            dbfs_chan #(.SS_CYC(SS_CYC)) u_ch (
                .i_clk_sys    (i_clk_sys),
                .i_nrst       (i_nrst),
                .i_go         (go[g]),
                .i_hot        (hot_q),
                .i_cyc_start  (cyc_start[g]),
                .i_ilim       (ilim[g]),
                .i_out_ok     (ok90[g]),
                .i_boot_low   (bootl[g]),
                .o_switch_on  (sw),
                .o_pull_down  (pd),
                .o_soft_start (ss),
                .o_good       (pg),
                .o_oc_fault   (oc)
            );
            always_ff @(posedge i_clk_sys)
            begin
                if (!i_nrst)
                begin
                    o_switch_node_on[g]        <= 1'b0;
                    o_switch_node_pull_down[g] <= 1'b0;
                    o_soft_start[g]            <= 1'b0;
                    o_output_good_flag[g]      <= 1'b0;
                    o_oc_fault[g]              <= 1'b0;
                end
                else
                begin
                    o_switch_node_on[g]        <= sw && !ilim[g];
                    o_switch_node_pull_down[g] <= pd;
                    o_soft_start[g]            <= ss;
                    o_output_good_flag[g]      <= pg;
                    o_oc_fault[g]              <= oc;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
            o_thermal_shutdown <= 1'b0;
        else
            o_thermal_shutdown <= hot_q;
    end
endmodule : dbfs_top

// ==== tb/dbfs_analog_model.sv ====
`timescale 1ns/10ps
// ==========================================
// Analog side model
// ==========================================
module dbfs_analog_model
    import dbfs_pkg::*;
#(
    parameter int SS_CYC = 64
)(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_nrst,
    // Commanded short per channel
    input  wire logic [1:0] i_short,
    // Device outputs
    input  wire logic [1:0] i_switch_on,
    input  wire logic [1:0] i_soft_start,
    input  wire logic [1:0] i_oc_fault,
    input  wire logic       i_hot,
    // Comparators
    output logic      [1:0] o_ilim_trip,
    output logic      [1:0] o_above_90
);
    int lvl [2];
    // Trip only while conducting into a short
    assign o_ilim_trip = i_short & i_switch_on;
    // Output ramps during soft-start, collapses on fault
    always_ff @(posedge i_clk_sys)
        for (int c = 0; c < 2; c++)
            if (!i_nrst || i_short[c] || i_oc_fault[c] || i_hot)
                lvl[c] <= 0;
            else if (i_soft_start[c] && lvl[c] < SS_CYC)
                lvl[c] <= lvl[c] + 1;
    assign o_above_90[0] = lvl[0] >= SS_CYC * 9 / 10;
    assign o_above_90[1] = lvl[1] >= SS_CYC * 9 / 10;
endmodule : dbfs_analog_model

// ==== tb/dbfs_monitor.sv ====
`timescale 1ns/10ps
// ==========================================
// Port checker
// ==========================================
module dbfs_monitor
    import dbfs_pkg::*;
#(
    parameter int SS_CYC = SS_CYC_DEF
)(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_nrst,
    // Comparators
    input  wire logic [1:0] i_ilim_trip,
    input  wire logic [1:0] i_output_above_90,
    // Outputs
    input  wire logic [1:0] o_switch_node_on,
    input  wire logic [1:0] o_switch_node_pull_down,
    input  wire logic [1:0] o_soft_start,
    input  wire logic [1:0] o_output_good_flag,
    input  wire logic [1:0] o_oc_fault,
    input  wire logic       o_thermal_shutdown
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    a_soft_good_low: assert property (
        (o_soft_start & o_output_good_flag) == 2'h0)
        else $error("good flag high in soft-start");
    a_good_drop: assert property (
        $fell(i_output_above_90[0]) |-> ##[1:5] !o_output_good_flag[0])
        else $error("good flag kept after output fell");
    a_fault_good_low: assert property (
        $rose(o_oc_fault[0]) |=> !o_output_good_flag[0] [*4])
        else $error("good flag high in fault");
    a_fault_switch_off: assert property (
        o_oc_fault[0] && $past(o_oc_fault[0]) |-> !o_switch_node_on[0])
        else $error("switch on in fault");
    a_hiccup_hold: assert property (
        $rose(o_oc_fault[0]) |-> o_oc_fault[0] [*8])
        else $error("hiccup wait too short");
    a_trip_cut: assert property (
        $rose(i_ilim_trip[0]) |-> ##[0:4] !o_switch_node_on[0])
        else $error("switch not cut on trip");
    a_hot_all_off: assert property (
        o_thermal_shutdown && $past(o_thermal_shutdown)
        |-> o_switch_node_on == 2'h0)
        else $error("switch on while hot");
    a_boot_width: assert property (
        $rose(o_switch_node_pull_down[1])
        |-> o_switch_node_pull_down[1] [*8])
        else $error("pull-down pulse too short");
endmodule : dbfs_monitor

bind dbfs_top dbfs_monitor #(.SS_CYC(SS_CYC)) u_mon (
    .i_clk_sys, .i_nrst, .i_ilim_trip, .i_output_above_90,
    .o_switch_node_on, .o_switch_node_pull_down, .o_soft_start,
    .o_output_good_flag, .o_oc_fault, .o_thermal_shutdown);

// ==== tb/dbfs_top_tb.sv ====
`timescale 1ns/10ps
module dbfs_top_tb;
    import dbfs_pkg::*;
    localparam int SS = 64;
    logic       clk, nrst, e1h, e1f, e2h, e2f, fs, sync, hot, sync_on;
    logic       therm, pv;
    logic [1:0] short, boot, ilim, above, on, pd, ss, good, oc;
    int         error_cnt, n_compared, t0, n, k;
    int         cyc = 0;
    int         sc = 0;
    int         tfall = 0;

    // ==========================================
    // Clock, design and model
    // ==========================================
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    dbfs_top #(.SS_CYC(SS)) dut (
        .i_clk_sys(clk), .i_nrst(nrst),
        .i_first_channel_enable_high(e1h),
        .i_first_channel_enable_float(e1f),
        .i_second_channel_enable_high(e2h),
        .i_second_channel_enable_float(e2f),
        .i_frequency_set_pin_at_rail(fs), .i_external_sync_input(sync),
        .i_ilim_trip(ilim), .i_output_above_90(above), .i_boot_low(boot),
        .i_over_temp(hot), .i_temp_recovered(!hot),
        .o_switch_node_on(on), .o_switch_node_pull_down(pd),
        .o_soft_start(ss), .o_output_good_flag(good), .o_oc_fault(oc),
        .o_thermal_shutdown(therm));
    dbfs_analog_model #(.SS_CYC(SS)) u_model (
        .i_clk_sys(clk), .i_nrst(nrst), .i_short(short),
        .i_switch_on(on), .i_soft_start(ss), .i_oc_fault(oc),
        .i_hot(therm), .o_ilim_trip(ilim), .o_above_90(above));

    // Sync at 1.25 MHz, falling edge every 20 cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        sc <= (sc == 9) ? 0 : sc + 1;
        if (!sync_on)
            sync <= 1'b1;
        else if (sc == 9)
            sync <= ~sync;
        if (sync_on && sc == 9 && sync)
            tfall <= cyc;
        if (cyc == 30000)
        begin
            error_cnt++;
            test_done;
        end
    end

    // ==========================================
    // Helpers
    // ==========================================
    task test_done;
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    task chk(input string nm, input logic [1:0] exp, got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s exp %0h got %0h", nm, exp, got);
        end
    endtask : chk
    task cnt(input string nm, input int lo, hi, got);
        n_compared++;
        if (got < lo || got > hi)
        begin
            error_cnt++;
            $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, got);
        end
    endtask : cnt
    task tick(input int c);
        repeat (c) @(posedge clk);
    endtask : tick
    task rst(input logic [3:0] en);
        @(posedge clk);
        nrst <= 1'b0;
        {e1h, e1f, e2h, e2f} <= en;
        {short, boot, hot, sync_on} <= 6'h00;
        tick(8);
        nrst <= 1'b1;
    endtask : rst
    // Cycles until the next switch-on rise
    task rise(input int c);
        t0 = cyc;
        while (on[c] && cyc - t0 < 300) tick(1);
        while (!on[c] && cyc - t0 < 300) tick(1);
        n = cyc - t0;
    endtask : rise

    // ==========================================
    // Scenarios
    // ==========================================
    task t_seq(input int a);
        rst(a ? 4'h6 : 4'h9);
        tick(8);
        chk("first start", a ? 2'h2 : 2'h1, ss);
        t0 = cyc;
        while (!ss[1 - a] && cyc - t0 < 500) tick(1);
        chk("lead output", 2'h1, {1'b0, above[a]});
        tick(3 * SS);
        chk("both good", 2'h3, good);
    endtask : t_seq
    task t_both;
        rst(4'hA);
        t0 = cyc;
        while (ss == 2'h0 && cyc - t0 < 50) tick(1);
        chk("start together", 2'h3, ss);
        tick(3 * SS);
        // Brief trips chop the on-time so cycle starts show
        short <= 2'h1;
        rise(0);
        rise(0);
        short <= 2'h0;
        cnt("default period", DEF_PER_CYC, DEF_PER_CYC, n);
        e1h <= 1'b0;
        tick(6);
        k = 0;
        repeat (60)
        begin
            if (on[0] !== 1'b0 || good[0] !== 1'b0)
                k = 1;
            tick(1);
        end
        cnt("disabled off", 0, 0, k);
    endtask : t_both
    task t_float;
        rst(4'h5);
        tick(300);
        chk("no start", 2'h0, ss | on);
    endtask : t_float
    task t_oc;
        rst(4'hA);
        tick(3 * SS);
        short <= 2'h1;
        t0 = cyc;
        k = 0;
        pv = 1'b1;
        while (!oc[0] && cyc - t0 < 3000)
        begin
            if (on[0] === 1'b1 && pv === 1'b0)
                k++;
            pv = on[0];
            tick(1);
        end
        cnt("tripped cycles", OC_OVF_COUNT - 1, OC_OVF_COUNT + 1, k);
        tick(2);
        chk("fault good", 2'h2, good);
        t0 = cyc;
        while (oc[0] && cyc - t0 < 5000) tick(1);
        n = HICCUP_SS * SS;
        cnt("hiccup wait", n - 3, n + 3, cyc - t0);
        t0 = cyc;
        while (!oc[0] && cyc - t0 < 3000) tick(1);
        chk("retry fault", 2'h1, oc);
        short <= 2'h0;
        t0 = cyc;
        while (oc[0] && cyc - t0 < 5000) tick(1);
        tick(3 * SS);
        chk("recovered", 2'h3, good);
    endtask : t_oc
    task t_hot;
        rst(4'hA);
        tick(3 * SS);
        hot <= 1'b1;
        tick(6);
        chk("hot off", 2'h0, on);
        chk("hot flag", 2'h1, {1'b0, therm});
        tick(20);
        hot <= 1'b0;
        t0 = cyc;
        while (ss == 2'h0 && cyc - t0 < 20) tick(1);
        chk("hot restart", 2'h3, ss);
    endtask : t_hot
    task t_boot;
        rst(4'h0);
        tick(4);
        boot <= 2'h3;
        tick(1);
        boot <= 2'h0;
        t0 = cyc;
        while (!pd[1] && cyc - t0 < 10) tick(1);
        chk("pull-down pair", 2'h3, pd);
        t0 = cyc;
        while (pd[1] && cyc - t0 < 40) tick(1);
        n = cyc - t0;
        cnt("pull-down width", BOOT_PULSE_CYC, BOOT_PULSE_CYC, n);
    endtask : t_boot
    task t_sync;
        rst(4'hA);
        sync_on <= 1'b1;
        tick(3 * SS);
        // Trips end each on-time, well short of overflow
        short <= 2'h3;
        rise(0);
        cnt("sync to start", 1, 6, cyc - tfall);
        rise(0);
        cnt("sync period", 40, 40, n);
        rise(1);
        rise(1);
        cnt("sync period 2", 40, 40, n);
    endtask : t_sync

    initial
    begin
        {nrst, e1h, e1f, e2h, e2f, fs, hot, sync_on} = 8'h04;
        {short, boot} = 4'h0;
        error_cnt = 0;
        n_compared = 0;
        t_seq(0);
        t_seq(1);
        t_both;
        t_float;
        t_oc;
        t_hot;
        t_boot;
        t_sync;
        test_done;
    end
endmodule : dbfs_top_tb
